//--- hw/tsl_pkg.sv
package tsl_pkg;

	// ----------------------------------------
	// Timing figures and clock rate.
	// ----------------------------------------
	localparam int CLK_KHZ          = 100000;
	localparam int SECOND_MS        = 1000;
	localparam int LONG_PRESS_MS    = 1000;
	localparam int REPEAT_START_MS  = 500;
	localparam int REPEAT_PERIOD_MS = 100;

	// ----------------------------------------
	// Register offsets and control fields.
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_UP_DLY  = 8'h04;
	localparam logic [7:0] REG_LO_DLY  = 8'h08;
	localparam logic [7:0] REG_UP_THR  = 8'h0c;
	localparam logic [7:0] REG_LO_THR  = 8'h10;
	localparam logic [7:0] REG_STATUS  = 8'h14;
	localparam logic [7:0] REG_LOOP    = 8'h18;
	localparam int         CTRL_MODE_LSB  = 0;
	localparam int         CTRL_INV_BIT   = 2;
	localparam int         CTRL_FAULT_LSB = 3;
	localparam int         CTRL_MENU_LSB  = 5;
	localparam logic [31:0] DASH_WORD  = 32'hffff_ffff;

	// ----------------------------------------
	// Menu positions that the buttons act on.
	// ----------------------------------------
	localparam logic [2:0] MENU_UP_DLY = 3'h3;
	localparam logic [2:0] MENU_LO_DLY = 3'h4;
	localparam logic [2:0] MENU_UP_THR = 3'h5;
	localparam logic [2:0] MENU_LO_THR = 3'h6;
	localparam logic [2:0] MENU_MODE   = 3'h7;

	// ----------------------------------------
	// Loop current levels in microamps.
	// ----------------------------------------
	localparam logic [15:0] UA_LOW      = 16'h0fa0;
	localparam logic [15:0] UA_HIGH     = 16'h4e20;
	localparam logic [15:0] UA_SAT_LO   = 16'h0ed8;
	localparam logic [15:0] UA_SAT_HI   = 16'h5014;
	localparam logic [15:0] UA_FAULT_HI = 16'h55f0;
	localparam logic [15:0] UA_FAULT_LO = 16'h0e10;
	localparam int          UA_PER_TENTH = 16;

	// ----------------------------------------
	// Setting limits and values after reset.
	// ----------------------------------------
	localparam logic [6:0] DLY_MIN    = 7'h00;
	localparam logic [6:0] DLY_MAX    = 7'h64;
	localparam logic [9:0] THR_MAX    = 10'h3e8;
	localparam logic [6:0] UP_DLY_RST = 7'h00;
	localparam logic [6:0] LO_DLY_RST = 7'h00;
	localparam logic [9:0] UP_THR_RST = 10'h320;
	localparam logic [9:0] LO_THR_RST = 10'h0c8;

	// ----------------------------------------
	// Types.
	// ----------------------------------------
	typedef enum logic [1:0] {
		proportional_output_mode,
		high_when_covered_mode,
		low_when_covered_mode
	} tsl_mode_t;

	typedef enum logic [1:0] {
		fault_off_mode,
		fault_high_current_mode,
		fault_low_current_mode
	} tsl_fault_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tsl_bus_req_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] q;
	} tsl_sync_t;

	typedef struct packed {
		tsl_mode_t   mode;
		logic        inv;
		tsl_fault_t  fault_mode;
		logic [2:0]  menu;
		logic [6:0]  up_dly;
		logic [6:0]  lo_dly;
		logic [9:0]  up_thr;
		logic [9:0]  lo_thr;
		logic        covered;
		logic [31:0] act_cyc;
		logic [6:0]  act_sec;
		logic [31:0] deact_cyc;
		logic [6:0]  deact_sec;
		logic [31:0] press_cyc;
		logic [31:0] rep_cyc;
		logic        prev_any;
		logic        prev_both;
		logic        both_seen;
		tsl_mode_t   pend_mode;
		logic        pend_valid;
		logic [15:0] loop_ua;
		logic [31:0] rdata;
	} tsl_state_t;

endpackage

//--- hw/tsl_btn_sync.sv
`timescale 1ns/1ns
module tsl_btn_sync
	import tsl_pkg::*;
(
	// Clock and reset.
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	// Raw button pins and clean levels.
	input  wire logic [1:0] btn_i,
	output logic      [1:0] btn_o
);

	tsl_sync_t s_reg;
	tsl_sync_t s_next;

	// Three stages; the clean level moves only when stages two and three agree.
	always_comb begin
		s_next    = s_reg;
		s_next.s1 = btn_i;
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		for (int i = 0; i < 2; i++) begin
			if (s_reg.s2[i] == s_reg.s3[i]) begin
				s_next.q[i] = s_reg.s3[i];
			end
		end
	end

	// State register.
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign btn_o = s_reg.q;

endmodule

//--- hw/tsl_loop_out.sv
`timescale 1ns/1ns
module tsl_loop_out
	import tsl_pkg::*;
#(
	parameter int SEC_CYC       = SECOND_MS * CLK_KHZ,
	parameter int LONG_CYC      = LONG_PRESS_MS * CLK_KHZ,
	parameter int REP_START_CYC = REPEAT_START_MS * CLK_KHZ,
	parameter int REP_PER_CYC   = REPEAT_PERIOD_MS * CLK_KHZ
)
(
	// Clock and reset.
	input  wire logic              core_clk_i,
	input  wire logic              rstn_i,
	// Register port.
	input  wire tsl_bus_req_t      bus_i,
	output logic            [31:0] rdata_o,
	// Front panel buttons.
	input  wire logic              inc_btn_i,
	input  wire logic              dec_btn_i,
	// Measurement and diagnostics.
	input  wire logic signed [11:0] level_i,
	input  wire logic              fault_i,
	// Loop output and display status.
	output logic            [15:0] loop_ua_o,
	output logic                   covered_o,
	output tsl_mode_t              mode_o,
	output logic                   fault_active_o,
	output logic                   disp_dash_o,
	output logic                   disp_show_mode_o
);

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	// Saturate a microamp figure into the loop limits.
	function automatic logic [15:0] clamp_ua(input int ua);
		return (ua < int'(UA_SAT_LO)) ? UA_SAT_LO : ((ua > int'(UA_SAT_HI)) ? UA_SAT_HI : ua[15:0]);
	endfunction
	// One step up or down, held inside zero and the limit.
	function automatic int step_val(input int v, input logic up, input int vmax);
		return up ? ((v >= vmax) ? vmax : v + 1) : ((v <= 0) ? 0 : v - 1);
	endfunction
	// Swap a delay between its two end values.
	function automatic logic [6:0] tog_dly(input logic [6:0] v);
		return (v == DLY_MAX) ? DLY_MIN : DLY_MAX;
	endfunction
	// Count up without wrapping.
	function automatic logic [31:0] sat_inc(input logic [31:0] c);
		return (c == 32'hffff_ffff) ? c : c + 32'h1;
	endfunction

	// ----------------------------------------
	// State and input conditioning.
	// ----------------------------------------
	localparam tsl_state_t STATE_RST = '{
		mode:       proportional_output_mode,
		fault_mode: fault_off_mode,
		pend_mode:  proportional_output_mode,
		up_dly:     UP_DLY_RST,
		lo_dly:     LO_DLY_RST,
		up_thr:     UP_THR_RST,
		lo_thr:     LO_THR_RST,
		loop_ua:    UA_LOW,
		default:    '0
	};
	tsl_state_t s_reg;
	tsl_state_t s_next;
	logic [1:0] btn;
	logic       btn_any;
	logic       btn_both;
	logic       btn_single;
	logic       long_press;
	logic       above_up;
	logic       below_lo;
	logic       edit_ok;
	logic       step_now;
	logic       toggle_now;
	// Buttons come from the panel pins and are synchronised first.
	tsl_btn_sync u_btn_sync (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .btn_i({dec_btn_i, inc_btn_i}), .btn_o(btn));

	// Press classification and the level comparisons.
	assign btn_any    = btn[0] | btn[1];
	assign btn_both   = btn[0] & btn[1];
	assign btn_single = btn_any & ~btn_both;
	assign long_press = s_reg.press_cyc >= 32'(LONG_CYC);
	assign above_up   = level_i > $signed({2'b00, s_reg.up_thr});
	assign below_lo   = level_i < $signed({2'b00, s_reg.lo_thr});
	assign edit_ok    = s_reg.mode != proportional_output_mode;
	assign step_now   = btn_single & ~s_reg.both_seen & (~s_reg.prev_any |
		(s_reg.press_cyc >= 32'(REP_START_CYC) & s_reg.rep_cyc == 32'(REP_PER_CYC - 1)));
	assign toggle_now = btn_both & ~s_reg.prev_both;

	// ----------------------------------------
	// Next-state logic.
	// ----------------------------------------
	always_comb begin
		int lin;
		lin    = 0;
		s_next = s_reg;
		if (!s_reg.covered && above_up) begin
			if (s_reg.act_sec >= s_reg.up_dly) begin
				s_next.covered = 1'b1;
				s_next.act_sec = '0;
				s_next.act_cyc = '0;
			end else if (s_reg.act_cyc == 32'(SEC_CYC - 1)) begin
				s_next.act_cyc = '0;
				s_next.act_sec = s_reg.act_sec + 7'h01;
			end else begin
				s_next.act_cyc = s_reg.act_cyc + 32'h1;
			end
		end else begin
			s_next.act_cyc = '0;
			s_next.act_sec = '0;
		end

		if (s_reg.covered && below_lo) begin
			if (s_reg.deact_sec >= s_reg.lo_dly) begin
				s_next.covered   = 1'b0;
				s_next.deact_sec = '0;
				s_next.deact_cyc = '0;
			end else if (s_reg.deact_cyc == 32'(SEC_CYC - 1)) begin
				s_next.deact_cyc = '0;
				s_next.deact_sec = s_reg.deact_sec + 7'h01;
			end else begin
				s_next.deact_cyc = s_reg.deact_cyc + 32'h1;
			end
		end else begin
			s_next.deact_cyc = '0;
			s_next.deact_sec = '0;
		end

		// Press duration, repeat phase and edge memory.
		s_next.press_cyc = btn_any ? sat_inc(s_reg.press_cyc) : '0;
		s_next.both_seen = btn_any & (s_reg.both_seen | btn_both);
		s_next.prev_any  = btn_any;
		s_next.prev_both = btn_both;
		if (btn_single && s_reg.press_cyc >= 32'(REP_START_CYC)) begin
			s_next.rep_cyc = (s_reg.rep_cyc == 32'(REP_PER_CYC - 1)) ? '0 : s_reg.rep_cyc + 32'h1;
		end else begin
			s_next.rep_cyc = '0;
		end

		if (btn_both && long_press) begin
			s_next.pend_mode  = proportional_output_mode;
			s_next.pend_valid = 1'b1;
		end else if (btn_single && !s_reg.both_seen && long_press && s_reg.menu == MENU_MODE) begin
			s_next.pend_mode  = btn[0] ? high_when_covered_mode : low_when_covered_mode;
			s_next.pend_valid = 1'b1;
		end
		// Chosen mode takes effect on release.
		if (!btn_any && s_reg.pend_valid) begin
			s_next.mode       = s_reg.pend_mode;
			s_next.pend_valid = 1'b0;
		end

		if (edit_ok) begin
			case (s_reg.menu)
				MENU_UP_DLY: begin
					if (step_now) begin
						s_next.up_dly = 7'(step_val(int'(s_reg.up_dly), btn[0], int'(DLY_MAX)));
					end else if (toggle_now) begin
						s_next.up_dly = tog_dly(s_reg.up_dly);
					end
				end
				MENU_LO_DLY: begin
					if (step_now) begin
						s_next.lo_dly = 7'(step_val(int'(s_reg.lo_dly), btn[0], int'(DLY_MAX)));
					end else if (toggle_now) begin
						s_next.lo_dly = tog_dly(s_reg.lo_dly);
					end
				end
				MENU_UP_THR: begin
					if (step_now) begin
						s_next.up_thr = 10'(step_val(int'(s_reg.up_thr), btn[0], int'(THR_MAX)));
					end
				end
				MENU_LO_THR: begin
					if (step_now) begin
						s_next.lo_thr = 10'(step_val(int'(s_reg.lo_thr), btn[0], int'(THR_MAX)));
					end
				end
				default: ;
			endcase
		end

		// Register writes; settings refuse writes outside two-state mode.
		if (bus_i.wr) begin
			case (bus_i.addr)
				REG_CTRL: begin
					if (bus_i.wdata[CTRL_MODE_LSB +: 2] != 2'h3) begin
						s_next.mode = tsl_mode_t'(bus_i.wdata[CTRL_MODE_LSB +: 2]);
					end
					if (bus_i.wdata[CTRL_FAULT_LSB +: 2] != 2'h3) begin
						s_next.fault_mode = tsl_fault_t'(bus_i.wdata[CTRL_FAULT_LSB +: 2]);
					end
					s_next.inv  = bus_i.wdata[CTRL_INV_BIT];
					s_next.menu = bus_i.wdata[CTRL_MENU_LSB +: 3];
				end
				REG_UP_DLY: begin
					if (edit_ok && bus_i.wdata[6:0] <= DLY_MAX) begin
						s_next.up_dly = bus_i.wdata[6:0];
					end
				end
				REG_LO_DLY: begin
					if (edit_ok && bus_i.wdata[6:0] <= DLY_MAX) begin
						s_next.lo_dly = bus_i.wdata[6:0];
					end
				end
				REG_UP_THR: begin
					if (edit_ok && bus_i.wdata[9:0] <= THR_MAX) begin
						s_next.up_thr = bus_i.wdata[9:0];
					end
				end
				REG_LO_THR: begin
					if (edit_ok && bus_i.wdata[9:0] <= THR_MAX) begin
						s_next.lo_thr = bus_i.wdata[9:0];
					end
				end
				default: ;
			endcase
		end

		// Read data stand for one cycle only.
		s_next.rdata = '0;
		if (bus_i.rd) begin
			case (bus_i.addr)
				REG_CTRL:   s_next.rdata = {24'h0, s_reg.menu, s_reg.fault_mode, s_reg.inv, s_reg.mode};
				REG_UP_DLY: s_next.rdata = edit_ok ? {25'h0, s_reg.up_dly} : DASH_WORD;
				REG_LO_DLY: s_next.rdata = edit_ok ? {25'h0, s_reg.lo_dly} : DASH_WORD;
				REG_UP_THR: s_next.rdata = edit_ok ? {22'h0, s_reg.up_thr} : DASH_WORD;
				REG_LO_THR: s_next.rdata = edit_ok ? {22'h0, s_reg.lo_thr} : DASH_WORD;
				REG_STATUS: s_next.rdata = {27'h0, s_reg.pend_valid, fault_active_o, s_reg.mode, s_reg.covered};
				REG_LOOP:   s_next.rdata = {16'h0, s_reg.loop_ua};
				default:    s_next.rdata = '0;
			endcase
		end

		lin = s_reg.inv ? int'(UA_HIGH) - UA_PER_TENTH * int'(level_i) : int'(UA_LOW) + UA_PER_TENTH * int'(level_i);
		case (s_reg.mode)
			proportional_output_mode: s_next.loop_ua = clamp_ua(lin);
			high_when_covered_mode:   s_next.loop_ua = s_reg.covered ? UA_HIGH : UA_LOW;
			low_when_covered_mode:    s_next.loop_ua = s_reg.covered ? UA_LOW : UA_HIGH;
			default:                  s_next.loop_ua = UA_LOW;
		endcase
		if (fault_i && s_reg.fault_mode == fault_high_current_mode) begin
			s_next.loop_ua = UA_FAULT_HI;
		end else if (fault_i && s_reg.fault_mode == fault_low_current_mode) begin
			s_next.loop_ua = UA_FAULT_LO;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_reg <= STATE_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign rdata_o          = s_reg.rdata;
	assign loop_ua_o        = s_reg.loop_ua;
	assign covered_o        = s_reg.covered;
	assign mode_o           = s_reg.mode;
	assign fault_active_o   = s_reg.loop_ua == UA_FAULT_HI || s_reg.loop_ua == UA_FAULT_LO;
	assign disp_dash_o      = !edit_ok && s_reg.menu >= MENU_UP_DLY && s_reg.menu <= MENU_LO_THR;
	assign disp_show_mode_o = btn_any && s_reg.menu == MENU_MODE;

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);

	AST_PROP_LINEAR: assert property (
		(s_reg.mode == proportional_output_mode && !s_reg.inv && !fault_i && level_i >= 12'sd0 &&
			level_i <= 12'sd1000) |=> loop_ua_o == 16'(int'(UA_LOW) + UA_PER_TENTH * int'($past(level_i))))
		else $error("Proportional current does not follow level.");
	AST_TWO_LEVELS: assert property (
		(s_reg.mode != proportional_output_mode && !fault_i) |=> (loop_ua_o == UA_LOW || loop_ua_o == UA_HIGH))
		else $error("Two-state output left its two levels.");
	AST_NO_EDIT: assert property (
		(!edit_ok && bus_i.wr && bus_i.addr == REG_UP_THR) |=> $stable(s_reg.up_thr))
		else $error("Threshold changed in proportional mode.");
	AST_COVER_CAUSE: assert property (
		$rose(s_reg.covered) |-> $past(above_up))
		else $error("Covered without level above upper threshold.");
	AST_ACT_RESTART: assert property (
		(!above_up && !s_reg.covered) |=> (s_reg.act_sec == 7'h00 && s_reg.act_cyc == 32'h0))
		else $error("Activation timer not restarted.");
	AST_DEACT_RESTART: assert property (
		(!below_lo && s_reg.covered) |=> (s_reg.deact_sec == 7'h00 && s_reg.deact_cyc == 32'h0))
		else $error("Deactivation timer not restarted.");
	AST_HIGH_COVERED: assert property (
		(s_reg.mode == high_when_covered_mode && !fault_i) |=> loop_ua_o == ($past(s_reg.covered) ? UA_HIGH : UA_LOW))
		else $error("High-on-covered level wrong.");
	AST_LOW_COVERED: assert property (
		(s_reg.mode == low_when_covered_mode && !fault_i) |=> loop_ua_o == ($past(s_reg.covered) ? UA_LOW : UA_HIGH))
		else $error("Low-on-covered level wrong.");
	AST_RELEASE_APPLY: assert property (
		(s_reg.pend_valid && s_reg.pend_mode == high_when_covered_mode && !btn_any && !bus_i.wr)
			|=> mode_o == high_when_covered_mode)
		else $error("Mode not applied on release.");
	AST_BOTH_RESTORE: assert property (
		(btn_both && long_press) |=> (s_reg.pend_valid && s_reg.pend_mode == proportional_output_mode))
		else $error("Both-button hold did not arm proportional mode.");
	AST_CLAMP: assert property (
		(s_reg.mode == proportional_output_mode && !fault_i) |=> (loop_ua_o >= UA_SAT_LO && loop_ua_o <= UA_SAT_HI))
		else $error("Loop current outside its limits.");
	AST_FAULT_HIGH: assert property (
		(fault_i && s_reg.fault_mode == fault_high_current_mode) |=> loop_ua_o == UA_FAULT_HI)
		else $error("High fault current not forced.");
	AST_HYSTERESIS: assert property (
		(!above_up && !below_lo) |=> $stable(s_reg.covered))
		else $error("Decision changed between thresholds.");

	COV_COVERED: cover property ($rose(s_reg.covered));
	COV_UNCOVERED: cover property ($fell(s_reg.covered));
	COV_MODE_HIGH: cover property ($changed(mode_o) ##0 mode_o == high_when_covered_mode);
	COV_FAULT: cover property (fault_active_o);

endmodule

//--- testbench/tsl_loop_rx.sv
`timescale 1ns/1ns
module tsl_loop_rx (
	// Clock.
	input  wire logic        core_clk_i,
	// Loop current as it reaches the receiver.
	input  wire logic [15:0] loop_ua_i,
	output logic      [15:0] seen_ua_o
);
	// The receiver samples the loop current once per clock, so it lags by one cycle.
	always_ff @(posedge core_clk_i) begin
		seen_ua_o <= loop_ua_i;
	end
endmodule

//--- testbench/two_state_level_switch_output_tb_top.sv
`timescale 1ns/1ns
module two_state_level_switch_output_tb_top
	import tsl_pkg::*;
;
	// ----------------------------------------
	// Stimulus and observed signals.
	// ----------------------------------------
	logic                core_clk_i = 1'b0;
	logic                rstn_i     = 1'b0;
	tsl_bus_req_t        bus_i      = '0;
	logic                inc_btn_i  = 1'b0;
	logic                dec_btn_i  = 1'b0;
	logic                fault_i    = 1'b0;
	logic signed [11:0]  level_i    = 12'sh000;
	logic        [31:0]  rdata_o;
	logic        [15:0]  loop_ua_o;
	logic        [15:0]  seen_ua;
	logic                covered_o;
	tsl_mode_t           mode_o;
	logic                fault_active_o;
	logic                disp_dash_o;
	logic                disp_show_mode_o;
	logic        [31:0]  rd_val;
	int                  failures   = 0;
	int                  num_checks = 0;

	// The clock toggles every half period of 10 ns.
	always #5 core_clk_i = ~core_clk_i;

	// Short counts keep the delay and long-press tests brief.
	tsl_loop_out #(.SEC_CYC(20), .LONG_CYC(10), .REP_START_CYC(8), .REP_PER_CYC(3)) uut (
		.core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
		.inc_btn_i(inc_btn_i), .dec_btn_i(dec_btn_i), .level_i(level_i), .fault_i(fault_i),
		.loop_ua_o(loop_ua_o), .covered_o(covered_o), .mode_o(mode_o),
		.fault_active_o(fault_active_o), .disp_dash_o(disp_dash_o),
		.disp_show_mode_o(disp_show_mode_o)
	);

	// The receiver model sits on the loop.
	tsl_loop_rx rx (.core_clk_i(core_clk_i), .loop_ua_i(loop_ua_o), .seen_ua_o(seen_ua));

	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		bus_i.addr  <= a;
		bus_i.wdata <= d;
		bus_i.wr    <= 1'b1;
		@(posedge core_clk_i);
		bus_i.wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		bus_i.addr <= a;
		bus_i.rd   <= 1'b1;
		@(posedge core_clk_i);
		bus_i.rd <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic lvl(input logic signed [11:0] v, input int n);
		@(posedge core_clk_i);
		level_i <= v;
		tick(n);
	endtask

	task automatic press(input logic inc, input logic dec, input int n);
		@(posedge core_clk_i);
		inc_btn_i <= inc;
		dec_btn_i <= dec;
		tick(n);
		@(posedge core_clk_i);
		inc_btn_i <= 1'b0;
		dec_btn_i <= 1'b0;
		tick(8);
	endtask

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_prop();
		check(mode_o, proportional_output_mode, "mode after reset");
		check(loop_ua_o, 32'h0fa0, "zero level");
		lvl(12'sd250, 3);
		check(loop_ua_o, 32'h1f40, "quarter level");
		wr(REG_CTRL, 32'h04);
		tick(2);
		check(loop_ua_o, 32'h3e80, "inverted quarter");
		wr(REG_CTRL, 32'h00);
		lvl(12'sd1100, 3);
		check(loop_ua_o, UA_SAT_HI, "clamp high");
		lvl(-12'sd30, 3);
		check(loop_ua_o, UA_SAT_LO, "clamp low");
		wr(REG_CTRL, 32'h60);
		check(disp_dash_o, 1'b1, "dash in delay menu");
		wr(REG_UP_THR, 32'h05);
		rd(REG_UP_THR, rd_val);
		check(rd_val, DASH_WORD, "threshold hidden");
		tick(1);
		check(rdata_o, 32'h0, "read word stands one cycle");
		$display("test proportional done");
	endtask

	task automatic t_cover();
		wr(REG_CTRL, 32'h01);
		rd(REG_UP_THR, rd_val);
		check(rd_val, 32'h320, "threshold unchanged");
		wr(REG_UP_THR, 32'h3e9);
		rd(REG_UP_THR, rd_val);
		check(rd_val, {22'h0, UP_THR_RST}, "threshold beyond range refused");
		rd(REG_LO_THR, rd_val);
		check(rd_val, {22'h0, LO_THR_RST}, "lower threshold");
		wr(REG_UP_DLY, 32'h01);
		wr(REG_LO_DLY, 32'h01);
		lvl(12'sd801, 10);
		lvl(12'sd800, 2);
		lvl(12'sd801, 15);
		check(covered_o, 1'b0, "timer restarted");
		tick(12);
		check(covered_o, 1'b1, "covered after delay");
		check(loop_ua_o, UA_HIGH, "high when covered");
		check(seen_ua, UA_HIGH, "receiver sees high");
		lvl(12'sd500, 30);
		check(covered_o, 1'b1, "held between");
		wr(REG_CTRL, 32'h02);
		tick(2);
		check(loop_ua_o, UA_LOW, "low when covered");
		lvl(12'sd199, 10);
		lvl(12'sd200, 2);
		lvl(12'sd199, 15);
		check(covered_o, 1'b1, "deact restarted");
		tick(12);
		check(covered_o, 1'b0, "uncovered after delay");
		check(loop_ua_o, UA_HIGH, "high when uncovered");
		lvl(12'sd500, 3);
		check(loop_ua_o, UA_HIGH, "two levels only");
		$display("test two-state done");
	endtask

	task automatic t_fault();
		wr(REG_CTRL, 32'h0a);
		@(posedge core_clk_i);
		fault_i <= 1'b1;
		tick(3);
		check(loop_ua_o, UA_FAULT_HI, "fault current");
		check(fault_active_o, 1'b1, "fault overrides mode");
		@(posedge core_clk_i);
		fault_i <= 1'b0;
		tick(3);
		check(loop_ua_o, UA_HIGH, "mode after fault");
		wr(REG_CTRL, 32'h12);
		@(posedge core_clk_i);
		fault_i <= 1'b1;
		tick(3);
		check(loop_ua_o, UA_FAULT_LO, "low fault current");
		rd(REG_STATUS, rd_val);
		check(rd_val, 32'h0c, "status shows fault");
		rd(REG_LOOP, rd_val);
		check(rd_val, {16'h0, UA_FAULT_LO}, "loop register at fault");
		wr(REG_CTRL, 32'h1b);
		rd(REG_CTRL, rd_val);
		check(rd_val, 32'h12, "reserved codes ignored");
		@(posedge core_clk_i);
		fault_i <= 1'b0;
		tick(3);
		check(loop_ua_o, UA_HIGH, "mode after low fault");
		$display("test fault done");
	endtask

	task automatic t_buttons();
		wr(REG_CTRL, 32'he0);
		press(1'b1, 1'b0, 5);
		check(mode_o, proportional_output_mode, "short press");
		@(posedge core_clk_i);
		inc_btn_i <= 1'b1;
		tick(8);
		check(disp_show_mode_o, 1'b1, "mode shown while held");
		press(1'b1, 1'b0, 12);
		check(mode_o, high_when_covered_mode, "long inc");
		check(disp_show_mode_o, 1'b0, "current shown");
		press(1'b0, 1'b1, 20);
		check(mode_o, low_when_covered_mode, "long dec");
		press(1'b1, 1'b1, 20);
		check(mode_o, proportional_output_mode, "long both");
		wr(REG_CTRL, 32'ha1);
		press(1'b1, 1'b0, 5);
		rd(REG_UP_THR, rd_val);
		check(rd_val, 32'h321, "step up");
		press(1'b0, 1'b1, 5);
		rd(REG_UP_THR, rd_val);
		check(rd_val, 32'h320, "step down");
		press(1'b1, 1'b0, 20);
		rd(REG_UP_THR, rd_val);
		check({31'h0, rd_val > 32'h322}, 32'h1, "auto repeat");
		wr(REG_CTRL, 32'h61);
		wr(REG_UP_DLY, 32'h00);
		press(1'b1, 1'b1, 5);
		rd(REG_UP_DLY, rd_val);
		check(rd_val, 32'h64, "delay toggled to max");
		$display("test buttons done");
	endtask

	// A second reset in mid-run brings back the factory state.
	task automatic t_reset();
		lvl(12'sd0, 2);
		@(posedge core_clk_i);
		rstn_i <= 1'b0;
		tick(3);
		check(loop_ua_o, UA_LOW, "loop held in reset");
		@(posedge core_clk_i);
		rstn_i <= 1'b1;
		tick(2);
		check(mode_o, proportional_output_mode, "mode after second reset");
		check(loop_ua_o, UA_LOW, "zero level after reset");
		rd(REG_UP_DLY, rd_val);
		check(rd_val, DASH_WORD, "delay hidden after reset");
		$display("test reset done");
	endtask

	// Main sequence: reset, then each scenario in turn.
	initial begin
		repeat (10) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		tick(2);
		t_prop();
		t_cover();
		t_fault();
		t_buttons();
		t_reset();
		stop_test();
	end

	// Watchdog cuts a hang short well beyond the expected run.
	initial begin
		#200000;
		failures++;
		stop_test();
	end
endmodule
